//--- src/sysref_delay_calibration.sv
// SYSREF aperture delay calibration: registers, averaging engine, delay select
`timescale 1ns/1ns
`include "sysref_cal_defs.svh"

module sysref_delay_calibration (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Register port
  input wire sysref_cal_pkg::reg_req_t reg_req_in,
  output logic [7:0] reg_rdata_out,
  // Link pin
  input wire logic sysref_in,
  // Delay control and status
  output logic [16:0] aperture_delay_out,
  output logic cal_busy_out,
  output logic cal_fail_out
);
  import sysref_cal_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // 4^(code+1): shared by accumulation length and average count
  function automatic logic [8:0] pow4(input logic [1:0] code);
    pow4 = 9'h004 << {code, 1'b0};
  endfunction

  function automatic logic [15:0] max_period(input logic [1:0] code);
    case (code)
      2'h0: max_period = `MAX_PERIOD_ACC0;
      2'h1: max_period = `MAX_PERIOD_ACC1;
      2'h2: max_period = `MAX_PERIOD_ACC2;
      default: max_period = `MAX_PERIOD_ACC3;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic en_q, en_d;
  logic [3:0] cfg_q, cfg_d;
  logic [16:0] manual_q, manual_d;
  logic [7:0] rdata_q, rdata_d;
  logic [16:0] result_q, result_d;
  cal_state_t state_q, state_d;
  logic [23:0] result_word;

  // Flag only while enabled and finished
  assign result_word = {6'h00, en_q && (state_q == ST_DONE), result_q};

  always_comb begin
    en_d = en_q;
    cfg_d = cfg_q;
    manual_d = manual_q;
    rdata_d = rdata_q;
    if (reg_req_in.wr) begin
      case (reg_req_in.addr)
        `ADDR_CAL_ENABLE: en_d = reg_req_in.wdata[`CAL_ENABLE_BIT];
        `ADDR_CAL_CONFIG: cfg_d = reg_req_in.wdata[`AVG_FIELD_HI:`ACC_FIELD_LO];
        `ADDR_MANUAL_B0: manual_d[7:0] = reg_req_in.wdata;
        `ADDR_MANUAL_B1: manual_d[15:8] = reg_req_in.wdata;
        `ADDR_MANUAL_B2: manual_d[`INV_BIT] = reg_req_in.wdata[0];
        default: ;
      endcase
    end
    if (reg_req_in.rd) begin
      case (reg_req_in.addr)
        `ADDR_CAL_ENABLE: rdata_d = {7'h00, en_q};
        `ADDR_CAL_CONFIG: rdata_d = {4'h0, cfg_q};
        `ADDR_RESULT_B0: rdata_d = result_word[7:0];
        `ADDR_RESULT_B1: rdata_d = result_word[15:8];
        `ADDR_RESULT_B2: rdata_d = result_word[23:16];
        `ADDR_MANUAL_B0: rdata_d = manual_q[7:0];
        `ADDR_MANUAL_B1: rdata_d = manual_q[15:8];
        `ADDR_MANUAL_B2: rdata_d = {7'h00, manual_q[`INV_BIT]};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      en_q <= `CAL_ENABLE_RESET;
      cfg_q <= `CAL_CONFIG_RESET;
      manual_q <= `MANUAL_DELAY_RESET;
      rdata_q <= 8'h00;
    end else begin
      en_q <= en_d;
      cfg_q <= cfg_d;
      manual_q <= manual_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // SYSREF synchroniser and edge

  logic sr_meta_q, sr_sync_q, sr_last_q, en_last_q;
  logic sr_rise, cal_start;

  assign sr_rise = sr_sync_q & ~sr_last_q;
  assign cal_start = en_q & ~en_last_q;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sr_meta_q <= 1'b0;
      sr_sync_q <= 1'b0;
      sr_last_q <= 1'b0;
      en_last_q <= 1'b0;
    end else begin
      sr_meta_q <= sysref_in;
      sr_sync_q <= sr_meta_q;
      sr_last_q <= sr_sync_q;
      en_last_q <= en_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Calibration engine

  logic [8:0] cyc_q, cyc_d;
  logic [8:0] nacc_q, nacc_d;
  logic [16:0] sum_q, sum_d;
  logic [15:0] period_q, period_d;
  logic [16:0] delay_q, delay_d;
  logic busy_q, busy_d;
  logic fail_q, fail_d;
  logic [1:0] avg_code, acc_code;
  logic [8:0] acc_len, avg_cnt;
  logic [16:0] sum_next;
  logic [32:0] frac_wide;
  logic [15:0] frac;

  assign avg_code = cfg_q[`AVG_FIELD_HI:`AVG_FIELD_LO];
  assign acc_code = cfg_q[`ACC_FIELD_HI:`ACC_FIELD_LO];
  assign acc_len = pow4(acc_code);
  assign avg_cnt = pow4(avg_code);
  assign sum_next = sum_q + {16'h0000, sr_sync_q};
  // Fraction of time SYSREF is high; one bound shift covers averaging
  // Shift reaches 16 at the largest codes, so the amount is five bits wide
  assign frac_wide = ({16'h0000, sum_next} << `FRAC_SCALE_SHIFT)
                     >> ({2'h0, avg_code, 1'b0} + {2'h0, acc_code, 1'b0} + `NORM_SHIFT_BIAS);
  // All-high window would wrap, so saturate
  assign frac = (frac_wide[16:0] >= `FRAC_FULL) ? `FRAC_MAX : frac_wide[15:0];

  always_comb begin
    state_d = state_q;
    cyc_d = cyc_q;
    nacc_d = nacc_q;
    sum_d = sum_q;
    result_d = result_q;
    busy_d = 1'b0;
    fail_d = fail_q;
    period_d = sr_rise ? 16'h0000 : period_q + 16'h0001;
    if (!en_q) begin
      state_d = ST_IDLE;
      fail_d = 1'b0;
    end else if (cal_start) begin
      state_d = ST_WAIT_EDGE;
      nacc_d = 9'h000;
      sum_d = 17'h00000;
      period_d = 16'h0000;
      fail_d = 1'b0;
      busy_d = 1'b1;
    end else begin
      case (state_q)
        ST_WAIT_EDGE: begin
          busy_d = 1'b1;
          if (period_q >= max_period(acc_code)) begin
            state_d = ST_FAIL;
            busy_d = 1'b0;
            fail_d = 1'b1;
          end else if (sr_rise) begin
            state_d = ST_ACCUM;
            cyc_d = 9'h000;
          end
        end
        ST_ACCUM: begin
          busy_d = 1'b1;
          sum_d = sum_next;
          cyc_d = cyc_q + 9'h001;
          if (period_q >= max_period(acc_code)) begin
            state_d = ST_FAIL;
            busy_d = 1'b0;
            fail_d = 1'b1;
          end else if (cyc_q == acc_len - 9'h001) begin
            nacc_d = nacc_q + 9'h001;
            // Each window starts on a SYSREF edge, well inside the bound
            if (nacc_q == avg_cnt - 9'h001) begin
              state_d = ST_DONE;
              busy_d = 1'b0;
              result_d = {frac[15], frac[14:7], frac[6:0], 1'b0};
            end else begin
              state_d = ST_WAIT_EDGE;
            end
          end
        end
        ST_IDLE: ;
        ST_DONE: ;
        ST_FAIL: ;
        default: state_d = ST_IDLE;
      endcase
    end
    // Manual setting when disabled, calibrated result once done, hold otherwise
    if (!en_q) begin
      delay_d = manual_q;
    end else if (state_q == ST_DONE) begin
      delay_d = result_q;
    end else begin
      delay_d = delay_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_q <= ST_IDLE;
      cyc_q <= 9'h000;
      nacc_q <= 9'h000;
      sum_q <= 17'h00000;
      period_q <= 16'h0000;
      result_q <= 17'h00000;
      delay_q <= `MANUAL_DELAY_RESET;
      busy_q <= 1'b0;
      fail_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cyc_q <= cyc_d;
      nacc_q <= nacc_d;
      sum_q <= sum_d;
      period_q <= period_d;
      result_q <= result_d;
      delay_q <= delay_d;
      busy_q <= busy_d;
      fail_q <= fail_d;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign aperture_delay_out = delay_q;
  assign cal_busy_out = busy_q;
  assign cal_fail_out = fail_q;

endmodule // sysref_delay_calibration

//--- src/sysref_cal_defs.svh
// Register map, reset values and timing limits of the SYSREF delay calibration
`ifndef SYSREF_CAL_DEFS_SVH
`define SYSREF_CAL_DEFS_SVH

`define ADDR_CAL_ENABLE 12'h2B0
`define ADDR_CAL_CONFIG 12'h2B1
`define ADDR_RESULT_B0 12'h2B2
`define ADDR_RESULT_B1 12'h2B3
`define ADDR_RESULT_B2 12'h2B4
`define ADDR_MANUAL_B0 12'h2B5
`define ADDR_MANUAL_B1 12'h2B6
`define ADDR_MANUAL_B2 12'h2B7

`define CAL_ENABLE_RESET 1'h0
`define CAL_CONFIG_RESET 4'h5
`define MANUAL_DELAY_RESET 17'h00000
`define CAL_ENABLE_BIT 0
`define AVG_FIELD_HI 3
`define AVG_FIELD_LO 2
`define ACC_FIELD_HI 1
`define ACC_FIELD_LO 0
`define DONE_BIT 17
`define INV_BIT 16

`define MAX_PERIOD_ACC0 16'h0080
`define MAX_PERIOD_ACC1 16'h0680
`define MAX_PERIOD_ACC2 16'h1E80
`define MAX_PERIOD_ACC3 16'h7E80
`define FRAC_SCALE_SHIFT 16
`define FRAC_FULL 17'h10000
`define FRAC_MAX 16'hFFFF
`define NORM_SHIFT_BIAS 5'h04

`endif

//--- src/sysref_cal_pkg.sv
// Types shared by the SYSREF delay calibration block
package sysref_cal_pkg;

  typedef struct packed {
    logic [11:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_WAIT_EDGE = 5'b00010,
    ST_ACCUM = 5'b00100,
    ST_DONE = 5'b01000,
    ST_FAIL = 5'b10000
  } cal_state_t;

endpackage

//--- dv/sysref_cal_chk.sv
// Port checker for the SYSREF delay calibration block
`timescale 1ns/1ns
module sysref_cal_chk (
  // Design ports
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire sysref_cal_pkg::reg_req_t reg_req_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic sysref_in,
  input wire logic [16:0] aperture_delay_out,
  input wire logic cal_busy_out,
  input wire logic cal_fail_out
);
  import sysref_cal_pkg::*;
  logic en_q;
  logic [3:0] cfg_q;
  logic [31:0] cnt_q;
  logic [31:0] lim;
  logic [3:0] sum;
  // Mirror of the written enable and config, as software sees them
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      en_q <= 1'h0;
      cfg_q <= 4'h5;
      cnt_q <= 32'h0;
    end else begin
      if (reg_req_in.wr && reg_req_in.addr == 12'h2B0) en_q <= reg_req_in.wdata[0];
      if (reg_req_in.wr && reg_req_in.addr == 12'h2B1) cfg_q <= reg_req_in.wdata[3:0];
      cnt_q <= cal_busy_out ? cnt_q + 32'h1 : 32'h0;
    end
  end
  assign sum = {2'h0, cfg_q[3:2]} + {2'h0, cfg_q[1:0]} + 4'h2;
  assign lim = 32'h1C80 << {sum, 1'h0};
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_start; $rose(en_q) |-> ##[1:2] cal_busy_out; endproperty
  a_start: assert property (p_start) else $error("start missed");
  property p_idle; !en_q [*2] |-> !cal_busy_out && !cal_fail_out; endproperty
  a_idle: assert property (p_idle) else $error("active while off");
  property p_fail; cal_fail_out && en_q ##1 en_q |-> cal_fail_out; endproperty
  a_fail: assert property (p_fail) else $error("fail dropped");
  property p_hold; (en_q && !cal_busy_out) [*5] |-> $stable(aperture_delay_out); endproperty
  a_hold: assert property (p_hold) else $error("delay moved");
  property p_bound; cnt_q <= lim; endproperty
  a_bound: assert property (p_bound) else $error("run too long");
  property p_rd_en; reg_req_in.rd && reg_req_in.addr == 12'h2B0
    |=> reg_rdata_out == {7'h0, $past(en_q)}; endproperty
  a_rd_en: assert property (p_rd_en) else $error("enable read");
  property p_rd_cfg; reg_req_in.rd && reg_req_in.addr == 12'h2B1
    |=> reg_rdata_out == {4'h0, $past(cfg_q)}; endproperty
  a_rd_cfg: assert property (p_rd_cfg) else $error("config read");
  property p_done; reg_req_in.rd && reg_req_in.addr == 12'h2B4
    |=> reg_rdata_out[7:2] == 6'h0 && (!reg_rdata_out[1] || $past(en_q)); endproperty
  a_done: assert property (p_done) else $error("done read");
  c_start: cover property ($rose(cal_busy_out));
  c_fail: cover property ($rose(cal_fail_out));
  c_done: cover property (reg_req_in.rd && reg_req_in.addr == 12'h2B4 ##1 reg_rdata_out[1]);
endmodule // sysref_cal_chk
bind sysref_delay_calibration sysref_cal_chk sysref_cal_chk_inst (.clk_in(clk_in),
  .sys_rst_in(sys_rst_in), .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out),
  .sysref_in(sysref_in), .aperture_delay_out(aperture_delay_out),
  .cal_busy_out(cal_busy_out), .cal_fail_out(cal_fail_out));

//--- dv/sysref_source.sv
// Clock source model driving the SYSREF pin
`timescale 1ns/1ns
module sysref_source (
  // Clock and control
  input wire logic clk_in,
  input wire logic run_in,
  input wire logic [15:0] period_in,
  input wire logic [15:0] high_in,
  // SYSREF pin
  output logic sysref_out
);
  logic [15:0] ph_q = 16'h0;
  // Stands low when stopped, no stray edges
  always_ff @(posedge clk_in) begin
    ph_q <= (!run_in || ph_q >= period_in - 16'h1) ? 16'h0 : ph_q + 16'h1;
    sysref_out <= run_in && ph_q < high_in;
  end
endmodule // sysref_source

//--- dv/sysref_delay_calibration_tb.sv
// Self-checking bench for the SYSREF delay calibration block
`timescale 1ns/1ns
module sysref_delay_calibration_tb;
  import sysref_cal_pkg::*;
  logic clk_in = 1'h0;
  logic sys_rst_in = 1'h1;
  reg_req_t req = '0;
  logic [7:0] rdata;
  logic [16:0] delay;
  logic sysref, busy, fail;
  logic run = 1'h0;
  logic [15:0] per = 16'h40;
  logic [15:0] hi = 16'h28;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  sysref_delay_calibration sysref_delay_calibration_inst (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .reg_req_in(req), .reg_rdata_out(rdata), .sysref_in(sysref),
    .aperture_delay_out(delay), .cal_busy_out(busy), .cal_fail_out(fail));
  sysref_source sysref_source_inst (.clk_in(clk_in), .run_in(run), .period_in(per),
    .high_in(hi), .sysref_out(sysref));
  initial forever #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    req = '{addr: a, wr: 1'h1, rd: 1'h0, wdata: d};
    @(negedge clk_in);
    req.wr = 1'h0;
    @(negedge clk_in);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    req = '{addr: a, wr: 1'h0, rd: 1'h1, wdata: 8'h00};
    @(negedge clk_in);
    req.rd = 1'h0;
    @(negedge clk_in);
    chk({9'h0, rdata & m}, {9'h0, e});
  endtask
  // Bounded wait; a stuck busy shows up in the next compare
  task automatic wait_cal(input int lim);
    repeat (4) @(negedge clk_in);
    for (int i = 0; i < lim && busy !== 1'h0; i++) @(negedge clk_in);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(12'h2B0, 8'h00);
    rd(12'h2B1, 8'h05);
    rd(12'h2B8, 8'h00);
    chk(delay, 17'h00000);
    for (int c = 0; c < 16; c++) begin
      wr(12'h2B1, 8'hF0 | c[7:0]);
      rd(12'h2B1, c[7:0]);
    end
    wr(12'h2B0, 8'hFE);
    rd(12'h2B0, 8'h00);
  endtask
  task automatic t_manual();
    wr(12'h2B5, 8'hA5);
    wr(12'h2B6, 8'h3C);
    wr(12'h2B7, 8'hFF);
    chk(delay, 17'h13CA5);
    rd(12'h2B7, 8'h01);
  endtask
  // All samples high, so the fraction saturates
  task automatic t_cal();
    wr(12'h2B1, 8'h05);
    run = 1'h1;
    wr(12'h2B0, 8'h01);
    chk({16'h0, busy}, 17'h1);
    wait_cal(3000);
    wr(12'h2B2, 8'h00);
    rd(12'h2B2, 8'hFE);
    rd(12'h2B3, 8'hFF);
    rd(12'h2B4, 8'h03);
    wr(12'h2B5, 8'h11);
    chk(delay, 17'h1FFFE);
    wr(12'h2B0, 8'h01);
    chk({16'h0, busy}, 17'h0);
    rd(12'h2B4, 8'h03);
    wr(12'h2B0, 8'h00);
    rd(12'h2B4, 8'h00, 8'h02);
    chk(delay, 17'h13C11);
  endtask
  // One high sample in four windows of four: fraction 1/4, coarse at mid-scale
  task automatic t_partial();
    hi = 16'h2;
    wr(12'h2B1, 8'h00);
    wr(12'h2B0, 8'h01);
    wait_cal(1000);
    rd(12'h2B2, 8'h00);
    rd(12'h2B3, 8'h80);
    rd(12'h2B4, 8'h02);
    chk(delay, 17'h08000);
    chk({16'h0, fail}, 17'h0);
    wr(12'h2B0, 8'h00);
    chk(delay, 17'h13C11);
  endtask
  task automatic t_fail();
    per = 16'hC8;
    wr(12'h2B1, 8'h00);
    wr(12'h2B0, 8'h01);
    wait_cal(1000);
    chk({16'h0, fail}, 17'h1);
    rd(12'h2B4, 8'h00, 8'h02);
    chk(delay, 17'h13C11);
    wr(12'h2B0, 8'h00);
    chk({16'h0, fail}, 17'h0);
    run = 1'h0;
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk_in);
    sys_rst_in = 1'h0;
    t_regs();
    t_manual();
    t_cal();
    t_partial();
    t_fail();
    complete_run();
  end
endmodule // sysref_delay_calibration_tb
